// >>> t16op_pkg.sv
// Constants, register map and types for the 16-bit timer output and prescale block
package t16op_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_PRESC   = 8'h04;
  localparam logic [7:0] OFS_OUTCTL  = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0C;
  localparam logic [7:0] OFS_CMPA    = 8'h10;
  localparam logic [7:0] OFS_CAPT    = 8'h14;
  localparam logic [7:0] OFS_STAT    = 8'h18;
  localparam logic [7:0] OFS_MASK    = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_OS_BIT   = 2;   // One-shot pulse mode
  localparam int MODE_CAP_BIT  = 3;   // Capture on input A edge
  localparam int MODE_PSEL_BIT = 4;   // Shared pin: 1 output, 0 input B
  localparam int PRESC_ESA_LSB = 4;   // Input A edge select
  localparam int PRESC_ESB_LSB = 6;   // Input B edge select
  localparam int OC_TOE_BIT    = 0;   // Timer output enable
  localparam int OC_LVR_BIT    = 2;   // Output level reset
  localparam int OC_LVS_BIT    = 3;   // Output level set
  localparam int OC_OSPT_BIT   = 6;   // One-shot software trigger
  localparam int ST_MATCH_BIT  = 0;
  localparam int ST_CAPT_BIT   = 1;
  localparam int ST_OVF_BIT    = 2;
  localparam int ST_EDGEB_BIT  = 3;
  localparam int NUM_EVENTS    = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CMPA_RESET  = 16'hFFFF;
  localparam logic [7:0]  MODE_RESET  = 8'h00;
  localparam logic [7:0]  PRESC_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OPM_STOP     = 2'b00,   // Counter stopped and cleared
    OPM_FREE     = 2'b01,   // Free running
    OPM_CLR_EDGE = 2'b10,   // Clear and start on input A edge
    OPM_CLR_CMP  = 2'b11    // Clear and start on compare A match
  } t16op_opmode_t;

  typedef enum logic [1:0] {
    CKS_PCLK  = 2'b00,      // Peripheral clock
    CKS_DIV4  = 2'b01,
    CKS_DIV16 = 2'b10,
    CKS_EDGEA = 2'b11       // Valid edge of input A
  } t16op_cksel_t;

endpackage

// >>> t16op_top.sv
// 16-bit timer with output control, prescaler, input edge filters and AHB-Lite registers
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns

// Overview of operation
// RULE1: Software stops the timer before writing output control bits except trigger.
// RULE2: Output level set and reset bits always read back as zero.
// RULE3: Software trigger bit clears itself after the write; reads zero.
// RULE4: Software sets the trigger bit only in one-shot pulse mode.
// RULE5: Repeated trigger writes are spaced at least two count clocks apart.
// RULE6: With output disabled, enable and level bits are written in one byte.
// RULE7: Software writes the prescaler register only while the timer is stopped.
// RULE8: Input A edge as count clock excludes its use for clear or capture.
// RULE9: Input high after reset gives a rising edge once counting is enabled.
// RULE10: Pin falling while stopped gives a falling edge on enable.
// RULE11: Pin rising while stopped gives a rising edge on enable.
// RULE12: Input A sampled at peripheral clock as count clock, else at count clock.
// RULE13: Edge accepted only after two equal successive samples; short pulses rejected.
// RULE14: Shared pin is either input B or timer output, never both.
// RULE15: Software avoids changing compare A while the counter runs.
// RULE16: Event count is read straight from the counter register.
// RULE17: Counter runs while mode bits are nonzero, stops and clears at zero.
// RULE18: Software trigger in one-shot mode clears, starts and begins one pulse.
module t16op_top
  import t16op_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        TIMER_INPUT_A,
  input  wire logic        SHARED_PIN_I,
  output logic             SHARED_PIN_O,
  output logic             SHARED_PIN_OE,
  output logic             IRQ
);
  import t16op_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]            mode_q;
  logic [7:0]            presc_q;
  logic                  toe_q;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic [CNT_W-1:0]      cmpa_q;
  logic [CNT_W-1:0]      capt_q;
  logic [NUM_EVENTS-1:0] stat_q, mask_q;
  logic [3:0]            div_q;
  logic                  smp_a_q, filt_a_q, smp_b_q, filt_b_q;
  logic                  tout_q, tout_d;
  logic                  trig_q;
  logic                  wr_q;
  logic [7:0]            addr_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        addr_ph   = HSEL & HREADY & HTRANS[1];
  wire [7:0]  addr_a    = HADDR[7:0];
  wire        wr_mode   = wr_q & (addr_q == OFS_MODE);
  wire        wr_presc  = wr_q & (addr_q == OFS_PRESC);
  wire        wr_outctl = wr_q & (addr_q == OFS_OUTCTL);
  wire        wr_cmpa   = wr_q & (addr_q == OFS_CMPA);
  wire        wr_stat   = wr_q & (addr_q == OFS_STAT);
  wire        wr_mask   = wr_q & (addr_q == OFS_MASK);
  wire        rd_en     = addr_ph & ~HWRITE;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  wire t16op_opmode_t opm  = t16op_opmode_t'(mode_q[1:0]);
  wire t16op_cksel_t  cks  = t16op_cksel_t'(presc_q[1:0]);
  wire       running  = (opm != OPM_STOP);                          // [RULE17]
  wire       os_mode  = mode_q[MODE_OS_BIT];
  wire       cap_en   = mode_q[MODE_CAP_BIT];
  wire       pin_out  = mode_q[MODE_PSEL_BIT];
  wire [1:0] esel_a   = presc_q[PRESC_ESA_LSB +: 2];
  wire [1:0] esel_b   = presc_q[PRESC_ESB_LSB +: 2];
  wire       edge_clk = (cks == CKS_EDGEA);

  // ----------------------------------------------------------------
  // Prescaler ticks
  // ----------------------------------------------------------------
  wire presc_tick = running & ((cks == CKS_PCLK)
                             | ((cks == CKS_DIV4) & (div_q[1:0] == 2'b11))
                             | ((cks == CKS_DIV16) & (div_q == 4'hF)));

  // Input A sample rate depends on its use
  wire samp_en_a = running & (edge_clk ? 1'b1 : presc_tick);         // [RULE12]
  wire samp_en_b = running & ~edge_clk & presc_tick & ~pin_out;

  // ----------------------------------------------------------------
  // Edge filters: a new level needs two equal samples
  // ----------------------------------------------------------------
  wire upd_a  = samp_en_a & (smp_a_q == TIMER_INPUT_A)
              & (filt_a_q != TIMER_INPUT_A);                         // [RULE13]
  wire upd_b  = samp_en_b & (smp_b_q == SHARED_PIN_I)
              & (filt_b_q != SHARED_PIN_I);                          // [RULE13]
  // Rise valid for codes 01 and 11, fall for codes 00 and 11
  wire edge_a = upd_a & (TIMER_INPUT_A ? esel_a[0] : ~(esel_a[1] ^ esel_a[0]));
  wire edge_b = upd_b & ~pin_out
              & (SHARED_PIN_I ? esel_b[0] : ~(esel_b[1] ^ esel_b[0])); // [RULE14]

  // ----------------------------------------------------------------
  // Counter events
  // ----------------------------------------------------------------
  wire trig_go  = trig_q & os_mode & running;                        // [RULE18]
  wire cnt_en   = running & (edge_clk ? edge_a : presc_tick);
  wire match_a  = cnt_en & (cnt_q == cmpa_q);
  wire ovf      = cnt_en & (cnt_q == {CNT_W{1'b1}});
  wire clr_edge = ~edge_clk & edge_a & (opm == OPM_CLR_EDGE);
  wire clr_cmp  = match_a & (opm == OPM_CLR_CMP);
  wire capt_ev  = ~edge_clk & edge_a & cap_en;
  wire [NUM_EVENTS-1:0] ev_set = {edge_b, ovf, capt_ev, match_a};

  // Counter next value
  always_comb begin
    cnt_d = cnt_q;
    if (!running) begin
      cnt_d = '0;                                                     // [RULE17]
    end else if (trig_go || clr_edge || clr_cmp) begin
      cnt_d = '0;                                                     // [RULE18]
    end else if (cnt_en) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // Output level next value
  always_comb begin
    tout_d = tout_q;
    if (wr_outctl && HWDATA[OC_LVS_BIT]) begin
      tout_d = 1'b1;
    end else if (wr_outctl && HWDATA[OC_LVR_BIT]) begin
      tout_d = 1'b0;
    end else if (trig_go) begin
      tout_d = 1'b1;                                                  // [RULE18]
    end else if (match_a && os_mode) begin
      tout_d = 1'b0;
    end else if (match_a && toe_q) begin
      tout_d = ~tout_q;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (addr_a)
      OFS_MODE:   rdata_d[7:0] = mode_q;
      OFS_PRESC:  rdata_d[7:0] = presc_q;
      OFS_OUTCTL: rdata_d[OC_TOE_BIT] = toe_q;                        // [RULE2] [RULE3]
      OFS_COUNT:  rdata_d[CNT_W-1:0] = cnt_q;                         // [RULE16]
      OFS_CMPA:   rdata_d[CNT_W-1:0] = cmpa_q;
      OFS_CAPT:   rdata_d[CNT_W-1:0] = capt_q;
      OFS_STAT:   rdata_d[NUM_EVENTS-1:0] = stat_q;
      OFS_MASK:   rdata_d[NUM_EVENTS-1:0] = mask_q;
      default:    rdata_d = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus slave registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      wr_q   <= addr_ph & HWRITE;
      addr_q <= addr_a;
      if (rd_en) begin
        HRDATA <= rdata_d;
      end
    end
  end

  // Software control registers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_q  <= MODE_RESET;
      presc_q <= PRESC_RESET;
      cmpa_q  <= CMPA_RESET;
      toe_q   <= 1'b0;
      mask_q  <= '0;
    end else begin
      if (wr_mode)   mode_q  <= HWDATA[7:0];
      if (wr_presc)  presc_q <= HWDATA[7:0];
      if (wr_cmpa)   cmpa_q  <= HWDATA[CNT_W-1:0];
      if (wr_outctl) toe_q   <= HWDATA[OC_TOE_BIT];
      if (wr_mask)   mask_q  <= HWDATA[NUM_EVENTS-1:0];
    end
  end

  // Trigger is a one-cycle pulse, never stored
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= wr_outctl & HWDATA[OC_OSPT_BIT];                     // [RULE3]
    end
  end

  // ----------------------------------------------------------------
  // Prescaler, counter, capture and output
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      div_q  <= 4'h0;
      cnt_q  <= '0;
      capt_q <= '0;
      tout_q <= 1'b0;
    end else begin
      div_q  <= running ? div_q + 4'h1 : 4'h0;
      cnt_q  <= cnt_d;
      tout_q <= tout_d;
      if (capt_ev) capt_q <= cnt_q;
    end
  end

  // Filters hold their level while stopped so edges show on enable
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      smp_a_q  <= 1'b0;
      filt_a_q <= 1'b0;                                               // [RULE9]
      smp_b_q  <= 1'b0;
      filt_b_q <= 1'b0;                                               // [RULE9]
    end else begin
      if (samp_en_a) smp_a_q <= TIMER_INPUT_A;                        // [RULE10] [RULE11]
      if (upd_a)     filt_a_q <= TIMER_INPUT_A;
      if (samp_en_b) smp_b_q <= SHARED_PIN_I;
      if (upd_b)     filt_b_q <= SHARED_PIN_I;
    end
  end

  // ----------------------------------------------------------------
  // Status, interrupt and pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      stat_q        <= '0;
      IRQ           <= 1'b0;
      SHARED_PIN_OE <= 1'b0;
    end else begin
      // Set wins over write-one-to-clear
      stat_q        <= ev_set | (stat_q & ~(wr_stat ? HWDATA[NUM_EVENTS-1:0] : '0));
      IRQ           <= |(stat_q & mask_q);
      SHARED_PIN_OE <= pin_out & toe_q;                               // [RULE14]
    end
  end

  assign SHARED_PIN_O = tout_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic rd_oc_q, rd_cnt_q;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_oc_q  <= 1'b0;
      rd_cnt_q <= 1'b0;
    end else begin
      rd_oc_q  <= rd_en & (addr_a == OFS_OUTCTL);
      rd_cnt_q <= rd_en & (addr_a == OFS_COUNT);
    end
  end

  sequence s_trig_write;
    wr_outctl && HWDATA[OC_OSPT_BIT] && os_mode && running
      && !wr_mode;
  endsequence

  sequence s_pulse_begun;
    ##2 (cnt_q == '0 || cnt_q == 1) && tout_q;
  endsequence

  a_level_read_zero: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE2]
    rd_oc_q |-> HRDATA[OC_LVS_BIT:OC_LVR_BIT] == 2'b00)
    else $error("level bits read nonzero");

  a_trig_read_zero: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE3]
    rd_oc_q |-> !HRDATA[OC_OSPT_BIT])
    else $error("trigger bit read nonzero");

  a_trig_self_clear: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE3]
    trig_q && !wr_outctl |=> !trig_q)
    else $error("trigger did not self clear");

  a_filter_hold: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE10] [RULE11]
    !running |=> $stable(filt_a_q) && $stable(filt_b_q))
    else $error("filter level moved while stopped");

  a_sample_rate: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE12]
    $changed(smp_a_q) |-> $past(samp_en_a))
    else $error("input A sampled off its sample clock");

  a_filter_two_smp: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE13]
    $changed(filt_a_q) |-> filt_a_q == $past(smp_a_q) && $past(running))
    else $error("filter accepted a single sample");

  a_pin_exclusive: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE14]
    SHARED_PIN_OE |-> $past(pin_out) && !$past(edge_b))
    else $error("shared pin used both ways");

  a_count_readback: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE16]
    rd_cnt_q |-> HRDATA[CNT_W-1:0] == $past(cnt_q))
    else $error("count read differs from counter");

  a_stop_clears: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE17]
    !running |=> cnt_q == '0)
    else $error("counter not cleared while stopped");

  a_oneshot_start: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE18]
    s_trig_write |-> s_pulse_begun)
    else $error("software trigger did not start pulse");

  a_edge_polarity: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE10] [RULE11]
    upd_a && ((esel_a == 2'b10) || (esel_a == 2'b01 && !TIMER_INPUT_A)
      || (esel_a == 2'b00 && TIMER_INPUT_A)) |-> !edge_a)
    else $error("input A edge of unselected polarity");

  a_stat_set_wins: assert property (@(posedge MCLK) disable iff (!RSTN)
    (|ev_set) |=> (stat_q & $past(ev_set)) == $past(ev_set))
    else $error("status event lost");

  a_irq_level: assert property (@(posedge MCLK) disable iff (!RSTN)
    IRQ == $past(|(stat_q & mask_q)))
    else $error("interrupt level differs from status and mask");

  a_stop_quiet: assert property (@(posedge MCLK) disable iff (!RSTN) // [RULE17]
    !running |-> !cnt_en && ev_set == '0)
    else $error("count or event while stopped");

endmodule // t16op_top

// >>> t16op_top_tb.sv
// Self-checking testbench for the 16-bit timer output and prescale block
`timescale 1ns/1ns
module t16op_top_tb;
  import t16op_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        MCLK;
  logic        RSTN;
  logic        HSEL;
  logic [31:0] HADDR;
  logic [1:0]  HTRANS;
  logic        HWRITE;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        TIMER_INPUT_A;
  logic        SHARED_PIN_I;
  logic        SHARED_PIN_O;
  logic        SHARED_PIN_OE;
  logic        IRQ;
  int          failures;
  int          n_checks;
  int          cycles;

  t16op_top dut (
    .MCLK(MCLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .TIMER_INPUT_A(TIMER_INPUT_A), .SHARED_PIN_I(SHARED_PIN_I),
    .SHARED_PIN_O(SHARED_PIN_O), .SHARED_PIN_OE(SHARED_PIN_OE), .IRQ(IRQ)
  );

  // ----------------------------------------------------------------
  // Clock, time-zero values and hang guard
  // ----------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One single word transfer; waits on hready in both phases
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge MCLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HADDR  <= {24'h000000, a};
    HWRITE <= is_wr;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    rd = HRDATA;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v & m, exp);
  endtask

  task automatic pin(input bit sel, input logic v, input int n);
    @(posedge MCLK);
    if (sel) SHARED_PIN_I <= v;
    else TIMER_INPUT_A <= v;
    repeat (n) @(posedge MCLK);
  endtask

  task automatic wait_o(input logic v, input int lim, output int n);
    n = 0;
    while (SHARED_PIN_O !== v && n < lim) begin
      @(posedge MCLK);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc(OFS_CMPA, 32'hFFFFFFFF, 32'h0000FFFF);
    rdc(OFS_MODE, 32'hFFFFFFFF, 32'h0);
    rdc(OFS_COUNT, 32'hFFFFFFFF, 32'h0);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
    chk({IRQ, SHARED_PIN_OE, HRESP}, 3'h0);
    wr(OFS_OUTCTL, 32'h0000000D);
    rdc(OFS_OUTCTL, 32'hFFFFFFFF, 32'h1);
    $display("done reset and output control");
  endtask

  // Input A edge as count clock, filter and pending edges across stop
  task automatic t_edges();
    wr(OFS_PRESC, 32'h13);
    wr(OFS_MODE, 32'h01);
    repeat (2) @(posedge MCLK);
    rdc(OFS_COUNT, 32'hFFFF, 32'h1);
    pin(1'b0, 1'b0, 0);
    pin(1'b0, 1'b1, 6);
    rdc(OFS_COUNT, 32'hFFFF, 32'h1);
    pin(1'b0, 1'b0, 4);
    pin(1'b0, 1'b1, 6);
    rdc(OFS_COUNT, 32'hFFFF, 32'h2);
    wr(OFS_MODE, 32'h00);
    rdc(OFS_COUNT, 32'hFFFF, 32'h0);
    wr(OFS_PRESC, 32'h03);
    pin(1'b0, 1'b0, 4);
    wr(OFS_MODE, 32'h01);
    repeat (2) @(posedge MCLK);
    rdc(OFS_COUNT, 32'hFFFF, 32'h1);
    wr(OFS_MODE, 32'h00);
    wr(OFS_PRESC, 32'h13);
    pin(1'b0, 1'b1, 4);
    wr(OFS_MODE, 32'h01);
    repeat (2) @(posedge MCLK);
    rdc(OFS_COUNT, 32'hFFFF, 32'h1);
    wr(OFS_MODE, 32'h00);
    $display("done input edges");
  endtask

  // Free running at peripheral clock: three cycles between read address phases
  task automatic t_free();
    logic [31:0] a;
    logic [31:0] b;
    wr(OFS_PRESC, 32'h00);
    wr(OFS_MODE, 32'h01);
    bus(1'b0, OFS_COUNT, 32'h0, a);
    bus(1'b0, OFS_COUNT, 32'h0, b);
    chk(b - a, 32'h3);
    wr(OFS_MODE, 32'h00);
    rdc(OFS_COUNT, 32'hFFFF, 32'h0);
    $display("done free running");
  endtask

  // Capture filter sampled at the divide-by-16 count clock
  task automatic t_capture();
    wr(OFS_PRESC, 32'h12);
    pin(1'b0, 1'b0, 2);
    wr(OFS_MODE, 32'h09);
    repeat (64) @(posedge MCLK);
    wr(OFS_STAT, 32'hF);
    pin(1'b0, 1'b1, 12);
    pin(1'b0, 1'b0, 64);
    rdc(OFS_STAT, 32'h2, 32'h0);
    pin(1'b0, 1'b1, 80);
    pin(1'b0, 1'b0, 40);
    rdc(OFS_STAT, 32'h2, 32'h2);
    wr(OFS_MODE, 32'h00);
    $display("done capture filter");
  endtask

  // Input B edge event, interrupt mask and clear, pin sharing
  task automatic t_irq_share();
    wr(OFS_PRESC, 32'h40);
    wr(OFS_MASK, 32'h0);
    wr(OFS_MODE, 32'h01);
    wr(OFS_STAT, 32'hF);
    pin(1'b1, 1'b1, 8);
    pin(1'b1, 1'b0, 8);
    rdc(OFS_STAT, 32'h8, 32'h8);
    chk(IRQ, 1'b0);
    wr(OFS_MASK, 32'h8);
    repeat (2) @(posedge MCLK);
    chk(IRQ, 1'b1);
    wr(OFS_STAT, 32'h8);
    repeat (2) @(posedge MCLK);
    chk(IRQ, 1'b0);
    chk(SHARED_PIN_OE, 1'b0);
    wr(OFS_MODE, 32'h00);
    wr(OFS_MODE, 32'h11);
    pin(1'b1, 1'b1, 8);
    pin(1'b1, 1'b0, 8);
    rdc(OFS_STAT, 32'h8, 32'h0);
    chk(SHARED_PIN_OE, 1'b1);
    wr(OFS_MODE, 32'h00);
    wr(OFS_MASK, 32'h0);
    $display("done interrupt and pin sharing");
  endtask

  // Software-triggered single pulse ending at compare A match
  task automatic t_oneshot();
    int n;
    wr(OFS_CMPA, 32'h20);
    wr(OFS_OUTCTL, 32'h05);
    wr(OFS_MODE, 32'h15);
    repeat (8) @(posedge MCLK);
    chk(SHARED_PIN_O, 1'b0);
    wr(OFS_OUTCTL, 32'h41);
    wait_o(1'b1, 10, n);
    chk(SHARED_PIN_O, 1'b1);
    wait_o(1'b0, 60, n);
    chk(SHARED_PIN_O, 1'b0);
    chk(n >= 30 && n <= 35, 1'b1);
    rdc(OFS_OUTCTL, 32'hFF, 32'h01);
    wr(OFS_OUTCTL, 32'h41);
    wait_o(1'b1, 10, n);
    chk(SHARED_PIN_O, 1'b1);
    wr(OFS_MODE, 32'h00);
    $display("done one-shot");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    failures      = 0;
    n_checks      = 0;
    cycles        = 0;
    RSTN          = 1'b0;
    HSEL          = 1'b0;
    HADDR         = 32'h0;
    HTRANS        = 2'b00;
    HWRITE        = 1'b0;
    HSIZE         = 3'h2;
    HWDATA        = 32'h0;
    TIMER_INPUT_A = 1'b1;
    SHARED_PIN_I  = 1'b0;
    repeat (4) @(posedge MCLK);
    RSTN <= 1'b1;
    t_reset();
    t_edges();
    t_free();
    t_capture();
    t_irq_share();
    t_oneshot();
    report_and_stop();
  end
endmodule // t16op_top_tb
